// [rtl/sensor_command_and_enable_ctrl.sv]
// Command decoder, address pointer and enable register of the sensor
`timescale 1ns/1ps
`include "sensor_cmd_consts.svh"

module sensor_command_and_enable_ctrl
	import sensor_cmd_pkg::*;
#(
	parameter int STARTUP_CYCLES = `PON_DELAY_CYCLES
) (
	// System clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// Link side, byte engine on its own clock
	input wire logic LINK_CLK,
	input wire logic LINK_ACTIVE,
	input wire logic LINK_WR_VALID,
	input wire logic LINK_WR_FIRST,
	input wire logic [7:0] LINK_WR_DATA,
	input wire logic LINK_RD_REQ,
	output logic LINK_READY,
	output logic LINK_RD_VALID,
	output logic [7:0] LINK_RD_DATA,
	// Conversion engine side
	input wire logic THRESHOLD_EVENT,
	output logic OSC_ON,
	output logic CONV_ENABLE,
	output logic WAIT_ENABLE,
	output logic INT_PENDING,
	output logic INT_N
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam logic [`STARTUP_CNT_W-1:0] STARTUP_LAST =
		`STARTUP_CNT_W'(STARTUP_CYCLES - 1);

	core_t c;
	core_t next_c;
	link_t l;
	link_t next_l;

	// ------------------------------------------------------------
	// Link domain: capture bytes, hand them over by toggle
	// ------------------------------------------------------------
	always_comb begin
		next_l = l;
		// Reset crosses in by two flops; no reset on these two
		next_l.rst_meta = RSTN;
		next_l.rst_sync = l.rst_meta;
		next_l.ack_meta = c.ack_tog;
		next_l.ack_sync = l.ack_meta;
		next_l.rd_valid = 1'b0;
		if (!l.rst_sync) begin
			next_l.state = LINK_IDLE;
			next_l.req_tog = 1'b0;
			next_l.kind = EV_WRITE;
			next_l.ev_data = 8'h00;
			next_l.ack_seen = 1'b0;
			next_l.rd_data = 8'h00;
			next_l.ready = 1'b0;
		end else begin
			case (l.state)
				LINK_IDLE: begin
					next_l.ready = 1'b1;
					if (l.ready && LINK_WR_VALID) begin
						next_l.kind = LINK_WR_FIRST ? EV_WRITE_FIRST : EV_WRITE;
						next_l.ev_data = LINK_WR_DATA;
						next_l.req_tog = ~l.req_tog;
						next_l.state = LINK_WAIT;
						next_l.ready = 1'b0;
					end else if (l.ready && LINK_RD_REQ) begin
						next_l.kind = EV_READ;
						next_l.req_tog = ~l.req_tog;
						next_l.state = LINK_WAIT;
						next_l.ready = 1'b0;
					end
				end
				LINK_WAIT: begin
					next_l.ready = 1'b0;
					if (l.ack_sync != l.ack_seen) begin
						next_l.ack_seen = l.ack_sync;
						// Word is stable: core holds it until next request
						if (l.kind == EV_READ) begin
							next_l.rd_data = c.rd_word;
							next_l.rd_valid = 1'b1;
						end
						next_l.state = LINK_IDLE;
						next_l.ready = 1'b1;
					end
				end
				default: begin
					next_l.state = LINK_IDLE;
					next_l.ready = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge LINK_CLK) begin
		l <= next_l;
	end

	assign LINK_READY = l.ready;
	assign LINK_RD_VALID = l.rd_valid;
	assign LINK_RD_DATA = l.rd_data;

	// ------------------------------------------------------------
	// Core domain: command decode and function enable
	// ------------------------------------------------------------
	always_comb begin
		logic int_clear;
		logic advance;
		logic is_cmd;
		logic [4:0] code;
		int_clear = 1'b0;
		advance = 1'b0;
		is_cmd = 1'b0;
		code = l.ev_data[`CMD_ADDR_HI:`CMD_ADDR_LO];
		next_c = c;
		next_c.tog_meta = l.req_tog;
		next_c.tog_sync = c.tog_meta;
		next_c.act_meta = LINK_ACTIVE;
		next_c.act_sync = c.act_meta;
		if (c.tog_sync != c.tog_seen) begin
			next_c.tog_seen = c.tog_sync;
			next_c.ack_tog = ~c.ack_tog;
			is_cmd = (l.kind == EV_WRITE_FIRST) &&
				l.ev_data[`CMD_SELECT_BIT];
			if (l.kind == EV_READ) begin
				// Pointer from the last valid command
				case (c.addr)
					`ADDR_FUNCTION_ENABLE: next_c.rd_word = c.fenable;
					`ADDR_STATUS: begin
						next_c.rd_word = `READ_ZERO;
						next_c.rd_word[`STATUS_INT_BIT] = c.int_flag;
					end
					default: next_c.rd_word = `READ_ZERO;
				endcase
				advance = 1'b1;
			end else if (is_cmd) begin
				case (xfer_type_t'(l.ev_data[`CMD_TYPE_HI:`CMD_TYPE_LO]))
					XFER_REPEAT, XFER_AUTOINC: begin
						next_c.addr = code;
						next_c.mode = xfer_type_t'(
							l.ev_data[`CMD_TYPE_HI:`CMD_TYPE_LO]);
					end
					XFER_SPECIAL: begin
						// Only the clear code acts; nop and others fall through
						if (code == `SF_INT_CLEAR) begin
							int_clear = 1'b1;
						end
					end
					default: ;
				endcase
			end else begin
				// Data byte, first one included when top bit clear
				if (c.addr == `ADDR_FUNCTION_ENABLE) begin
					// Reserved bits are not stored, they read back zero
					next_c.fenable = l.ev_data & `EN_WRITE_MASK;
				end
				advance = 1'b1;
			end
			if (advance && c.mode == XFER_AUTOINC) begin
				next_c.addr = c.addr + 5'h01;
			end
			// Repeat mode: address is simply left as it is
			if (advance && c.mode == XFER_REPEAT) begin
				next_c.addr = c.addr;
			end
		end
		// Set wins over clear; the clear itself leaves nothing behind
		next_c.int_flag = THRESHOLD_EVENT | (c.int_flag & ~int_clear);
		if (!next_c.fenable[`EN_POWER_BIT]) begin
			next_c.startup_cnt = '0;
			next_c.startup_done = 1'b0;
		end else if (!c.startup_done) begin
			if (c.startup_cnt == STARTUP_LAST) begin
				next_c.startup_done = 1'b1;
			end else begin
				next_c.startup_cnt = c.startup_cnt + `STARTUP_CNT_W'(1);
			end
		end
		next_c.osc_on = next_c.fenable[`EN_POWER_BIT] |
			c.act_sync;
		next_c.conv_en = next_c.fenable[`EN_CONV_BIT] &
			next_c.fenable[`EN_POWER_BIT] & next_c.startup_done;
		next_c.wait_en = next_c.fenable[`EN_WAIT_BIT] &
			next_c.fenable[`EN_POWER_BIT] & next_c.startup_done;
		next_c.int_pending = next_c.int_flag;
		next_c.int_n = ~(next_c.int_flag &
			next_c.fenable[`EN_IRQ_BIT]);
		if (!RSTN) begin
			next_c.tog_seen = 1'b0;
			next_c.ack_tog = 1'b0;
			next_c.addr = `ADDR_RESET;
			next_c.mode = XFER_REPEAT;
			next_c.fenable = `FUNCTION_ENABLE_RESET;
			next_c.int_flag = 1'b0;
			next_c.startup_cnt = '0;
			next_c.startup_done = 1'b0;
			next_c.rd_word = `READ_ZERO;
			next_c.osc_on = 1'b0;
			next_c.conv_en = 1'b0;
			next_c.wait_en = 1'b0;
			next_c.int_pending = 1'b0;
			next_c.int_n = 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		c <= next_c;
	end

	assign OSC_ON = c.osc_on;
	assign CONV_ENABLE = c.conv_en;
	assign WAIT_ENABLE = c.wait_en;
	assign INT_PENDING = c.int_pending;
	assign INT_N = c.int_n;

endmodule : sensor_command_and_enable_ctrl

// [rtl/sensor_cmd_consts.svh]
// Constants for the sensor command and enable controller
`ifndef SENSOR_CMD_CONSTS_SVH
`define SENSOR_CMD_CONSTS_SVH

// ----------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------
`define CMD_SELECT_BIT 7
`define CMD_TYPE_HI 6
`define CMD_TYPE_LO 5
`define CMD_ADDR_HI 4
`define CMD_ADDR_LO 0
`define SF_NOP 5'h00
`define SF_INT_CLEAR 5'h06

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_FUNCTION_ENABLE 5'h00
`define ADDR_STATUS 5'h13
`define ADDR_RESET 5'h00

// ----------------------------------------------------------------
// Function enable fields and reset values
// ----------------------------------------------------------------
`define EN_POWER_BIT 0
`define EN_CONV_BIT 1
`define EN_WAIT_BIT 3
`define EN_IRQ_BIT 4
`define EN_WRITE_MASK 8'h1B
`define FUNCTION_ENABLE_RESET 8'h00
`define STATUS_INT_BIT 4
`define READ_ZERO 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PON_DELAY_NS 2400000
`define MCLK_PERIOD_NS 25
`define PON_DELAY_CYCLES \
	((`PON_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define STARTUP_CNT_W 17

`endif

// [rtl/sensor_cmd_pkg.sv]
// Types for the sensor command and enable controller
`include "sensor_cmd_consts.svh"

package sensor_cmd_pkg;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		XFER_REPEAT = 2'h0,
		XFER_AUTOINC = 2'h1,
		XFER_RESERVED = 2'h2,
		XFER_SPECIAL = 2'h3
	} xfer_type_t;

	typedef enum logic [1:0] {
		EV_WRITE_FIRST = 2'h0,
		EV_WRITE = 2'h1,
		EV_READ = 2'h3
	} ev_kind_t;

	typedef enum logic {
		LINK_IDLE = 1'b0,
		LINK_WAIT = 1'b1
	} link_state_t;

	// ------------------------------------------------------------
	// State records
	// ------------------------------------------------------------
	typedef struct packed {
		logic tog_meta;
		logic tog_sync;
		logic tog_seen;
		logic act_meta;
		logic act_sync;
		logic ack_tog;
		logic [4:0] addr;
		xfer_type_t mode;
		logic [7:0] fenable;
		logic int_flag;
		logic [`STARTUP_CNT_W-1:0] startup_cnt;
		logic startup_done;
		logic [7:0] rd_word;
		logic osc_on;
		logic conv_en;
		logic wait_en;
		logic int_n;
		logic int_pending;
	} core_t;

	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		link_state_t state;
		logic req_tog;
		ev_kind_t kind;
		logic [7:0] ev_data;
		logic ack_meta;
		logic ack_sync;
		logic ack_seen;
		logic [7:0] rd_data;
		logic rd_valid;
		logic ready;
	} link_t;

endpackage : sensor_cmd_pkg

// [tb/sensor_cmd_checker.sv]
// Assertions on the core outputs of the command controller
`timescale 1ns/1ps
module sensor_cmd_checker #(
	parameter int STARTUP_CYCLES = 16
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// Watched ports
	input wire logic LINK_ACTIVE,
	input wire logic THRESHOLD_EVENT,
	input wire logic OSC_ON,
	input wire logic CONV_ENABLE,
	input wire logic WAIT_ENABLE,
	input wire logic INT_PENDING,
	input wire logic INT_N
);
	// ------------------------------------------------------------
	// Oscillator run length, saturating to stay small
	// ------------------------------------------------------------
	int osc_cnt;
	always_ff @(posedge MCLK) begin
		if (!RSTN || !OSC_ON)
			osc_cnt <= 0;
		else if (osc_cnt < 1000)
			osc_cnt <= osc_cnt + 1;
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	property p_int_set;
		THRESHOLD_EVENT |-> ##[1:2] INT_PENDING;
	endproperty
	a_int_set: assert property (p_int_set) else $error("flag missed");
	property p_int_rose;
		$rose(INT_PENDING) |->
			$past(THRESHOLD_EVENT, 2) || $past(THRESHOLD_EVENT);
	endproperty
	a_int_rose: assert property (p_int_rose) else $error("flag no cause");
	property p_int_pin;
		!INT_N |-> INT_PENDING;
	endproperty
	a_int_pin: assert property (p_int_pin) else $error("pin no flag");
	property p_conv_osc;
		CONV_ENABLE |-> OSC_ON;
	endproperty
	a_conv_osc: assert property (p_conv_osc) else $error("conv no osc");
	property p_wait_osc;
		WAIT_ENABLE |-> OSC_ON;
	endproperty
	a_wait_osc: assert property (p_wait_osc) else $error("wait no osc");
	property p_startup;
		$rose(CONV_ENABLE) |->
			osc_cnt >= (STARTUP_CYCLES < 1000 ? STARTUP_CYCLES : 1000);
	endproperty
	a_startup: assert property (p_startup) else $error("early conv");
	property p_bus_osc;
		LINK_ACTIVE [*5] |-> OSC_ON;
	endproperty
	a_bus_osc: assert property (p_bus_osc) else $error("osc off in bus");
	property p_rst_vals;
		disable iff (1'b0) !RSTN |=> !OSC_ON && INT_N && !INT_PENDING;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset value");
endmodule : sensor_cmd_checker

bind sensor_command_and_enable_ctrl sensor_cmd_checker #(
	.STARTUP_CYCLES(STARTUP_CYCLES)
) chk_u (.MCLK(MCLK), .RSTN(RSTN), .LINK_ACTIVE(LINK_ACTIVE),
	.THRESHOLD_EVENT(THRESHOLD_EVENT), .OSC_ON(OSC_ON),
	.CONV_ENABLE(CONV_ENABLE), .WAIT_ENABLE(WAIT_ENABLE),
	.INT_PENDING(INT_PENDING), .INT_N(INT_N));

// [tb/link_host.sv]
// Host model driving the byte link of the command controller
`timescale 1ns/1ps
module link_host (
	// Link clock
	input wire logic LINK_CLK,
	// Requests
	output logic LINK_ACTIVE,
	output logic LINK_WR_VALID,
	output logic LINK_WR_FIRST,
	output logic [7:0] LINK_WR_DATA,
	output logic LINK_RD_REQ,
	// Answers
	input wire logic LINK_READY,
	input wire logic LINK_RD_VALID,
	input wire logic [7:0] LINK_RD_DATA
);
	initial begin
		LINK_ACTIVE = 1'b0;
		LINK_WR_VALID = 1'b0;
		LINK_WR_FIRST = 1'b0;
		LINK_WR_DATA = 8'hA5;
		LINK_RD_REQ = 1'b0;
	end
	// ------------------------------------------------------------
	// Link tasks
	// ------------------------------------------------------------
	task automatic wait_on(input logic rdy);
		int n;
		n = 0;
		do begin
			// Look just past the edge, once the registers have settled
			@(posedge LINK_CLK);
			#1;
			n++;
			if (n > 60)
				tb_top.hang();
		end while ((rdy ? LINK_READY : LINK_RD_VALID) !== 1'b1);
	endtask : wait_on
	// Commands carry the top bit, enable writes keep reserved bits 0
	task automatic wr(input logic first, input logic [7:0] d);
		wait_on(1'b1);
		LINK_WR_VALID <= 1'b1;
		LINK_WR_FIRST <= first;
		LINK_WR_DATA <= d;
		@(posedge LINK_CLK);
		LINK_WR_VALID <= 1'b0;
		LINK_WR_FIRST <= 1'b0;
		// Stale data inverted so nothing relies on it
		LINK_WR_DATA <= ~d;
	endtask : wr
	task automatic rd(output logic [7:0] d);
		wait_on(1'b1);
		LINK_RD_REQ <= 1'b1;
		@(posedge LINK_CLK);
		LINK_RD_REQ <= 1'b0;
		wait_on(1'b0);
		d = LINK_RD_DATA;
	endtask : rd
	task automatic start();
		@(posedge LINK_CLK);
		LINK_ACTIVE <= 1'b1;
	endtask : start
	task automatic stop();
		wait_on(1'b1);
		LINK_ACTIVE <= 1'b0;
	endtask : stop
endmodule : link_host

// [tb/tb_top.sv]
// Self-checking bench for the command and enable controller
`timescale 1ns/1ps
module tb_top;
	// Short startup so the run stays brief
	localparam int SC = 16;
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic rstn = 1'b0;
	logic evt = 1'b0;
	logic act, wv, wf, rq, rdy, rv, osc, conv, wen, pend, int_n;
	logic [7:0] wd, rdat;
	int err_count = 0;
	int cmp_count = 0;
	initial forever #12.5 mclk = ~mclk;
	initial begin
		#3.3;
		forever #6 lclk = ~lclk;
	end
	sensor_command_and_enable_ctrl #(.STARTUP_CYCLES(SC)) dut_u (
		.MCLK(mclk), .RSTN(rstn), .LINK_CLK(lclk), .LINK_ACTIVE(act),
		.LINK_WR_VALID(wv), .LINK_WR_FIRST(wf), .LINK_WR_DATA(wd),
		.LINK_RD_REQ(rq), .LINK_READY(rdy), .LINK_RD_VALID(rv),
		.LINK_RD_DATA(rdat), .THRESHOLD_EVENT(evt), .OSC_ON(osc),
		.CONV_ENABLE(conv), .WAIT_ENABLE(wen), .INT_PENDING(pend),
		.INT_N(int_n));
	link_host host_u (.LINK_CLK(lclk), .LINK_ACTIVE(act),
		.LINK_WR_VALID(wv), .LINK_WR_FIRST(wf), .LINK_WR_DATA(wd),
		.LINK_RD_REQ(rq), .LINK_READY(rdy), .LINK_RD_VALID(rv),
		.LINK_RD_DATA(rdat));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t byte %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t bit %b exp %b", $time, got, exp);
		end
	endtask : chkb
	task automatic rdc(input logic [7:0] exp);
		logic [7:0] d;
		host_u.rd(d);
		chk(d, exp);
	endtask : rdc
	task automatic mw(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : mw
	task automatic pulse();
		@(posedge mclk);
		evt <= 1'b1;
		@(posedge mclk);
		evt <= 1'b0;
		mw(3);
	endtask : pulse
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic hang();
		err_count++;
		$display("[FAIL] %0t wait ran out", $time);
		report_and_stop();
	endtask : hang
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		mw(2);
		chkb(int_n, 1'b1);
		chkb(osc, 1'b0);
		$display("test reset done");
		host_u.start();
		host_u.wr(1'b1, 8'h80);
		host_u.wr(1'b0, 8'h1B);
		host_u.stop();
		mw(1);
		chkb(conv, 1'b0);
		mw(SC + 4);
		chkb(osc, 1'b1);
		chkb(conv, 1'b1);
		chkb(wen, 1'b1);
		host_u.start();
		rdc(8'h1B);
		rdc(8'h1B);
		host_u.stop();
		$display("test enable done");
		pulse();
		chkb(pend, 1'b1);
		chkb(int_n, 1'b0);
		host_u.start();
		host_u.wr(1'b1, 8'hE0);
		host_u.wr(1'b1, 8'hC6);
		rdc(8'h1B);
		host_u.stop();
		mw(2);
		chkb(pend, 1'b1);
		host_u.start();
		host_u.wr(1'b1, 8'hE6);
		host_u.stop();
		mw(2);
		chkb(pend, 1'b0);
		chkb(int_n, 1'b1);
		pulse();
		chkb(pend, 1'b1);
		$display("test special done");
		host_u.start();
		host_u.wr(1'b1, 8'h0B);
		host_u.wr(1'b1, 8'hBF);
		rdc(8'h00);
		rdc(8'h0B);
		host_u.wr(1'b1, 8'hB2);
		rdc(8'h00);
		rdc(8'h10);
		host_u.stop();
		mw(2);
		chkb(int_n, 1'b1);
		$display("test pointer done");
		host_u.start();
		host_u.wr(1'b1, 8'h80);
		host_u.wr(1'b0, 8'h00);
		mw(8);
		chkb(osc, 1'b1);
		host_u.stop();
		mw(4);
		chkb(osc, 1'b0);
		chkb(conv, 1'b0);
		$display("test power done");
		report_and_stop();
	end
endmodule : tb_top
